// >>> apo_consts.svh
// constants for the pipelined converter output port
// assumes inclusion by bare name from the package and the design file
`ifndef APO_CONSTS_SVH
`define APO_CONSTS_SVH

// word layout
`define APO_WORD_W 8
`define APO_NIB_W 4
`define APO_UPPER_LSB 4
`define APO_LOWER_LSB 0

// straight binary reference points
`define APO_CODE_ZERO 8'h00
`define APO_CODE_HALF_M1 8'h7F
`define APO_CODE_HALF 8'h80
`define APO_CODE_FULL 8'hFF

// buffering
`define APO_FIFO_DEPTH 8

// timing, clock rates in Hz, latency in half clock cycles
`define APO_MCLK_HZ 100000000
`define APO_CONV_MIN_HZ 20000000
`define APO_CLK_FLOOR_HZ 500000
`define APO_LATENCY_HALF 5

// reset values
`define APO_RST_OE_N 1'b1
`define APO_RST_LANE 1'b0

`endif

// >>> apo_pkg.sv
// types shared by the converter output port
// assumes apo_consts.svh is on the include path
`include "apo_consts.svh"

package apo_pkg;

   // pipeline fill progress, gray coded along the fill path
   typedef enum logic [1:0] {
      APO_EMPTY = 2'b00,
      APO_FILL1 = 2'b01,
      APO_FILL2 = 2'b11,
      APO_RUN = 2'b10
   } apo_fill_t;

   // falling edge sample and hold, two lower lanes
   typedef struct packed {
      logic [`APO_WORD_W-1:0] code_a;
      logic [`APO_WORD_W-1:0] code_b;
      logic lane;
      logic last_lane;
      logic taken;
   } apo_hold_t;

   // rising edge pipeline state
   typedef struct packed {
      logic oe_s1;
      logic oe_s2;
      apo_fill_t fill;
      logic [`APO_NIB_W-1:0] upper_stage_result;
      logic up_lane;
      logic [`APO_NIB_W-1:0] lower_stage_result;
      logic [`APO_NIB_W-1:0] lo_upper;
      logic [`APO_WORD_W-1:0] word;
      logic word_v;
      logic overrun;
   } apo_state_t;

endpackage

// >>> apo_port.sv
// pipelined two-step converter output port and its capture buffer
// assumes the quantised input code is stable around each falling edge of mclk
`timescale 1ns/1ps
`include "apo_consts.svh"

module apo_fifo #(
   parameter int WIDTH = `APO_WORD_W,
   parameter int DEPTH = `APO_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } apo_fifo_st_t;

   apo_fifo_st_t st_r;
   apo_fifo_st_t st_nxt;
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("fifo depth must be a power of two of at least 2");
      end
      if (WIDTH < 1) begin
         $error("fifo width must be at least 1");
      end
   end

   assign in_ready = (st_r.count != DEPTH[AW:0]);
   assign out_valid = (st_r.count != '0);
   assign out_data = st_r.mem[st_r.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd = st_r.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: st_nxt.count = st_r.count + 1'b1;
         2'b01: st_nxt.count = st_r.count - 1'b1;
         default: st_nxt.count = st_r.count;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // apo_fifo

// falling edge sample and hold; lane 0 stands for lower group A, lane 1 for
// lower group B, and each lane keeps its sample for two rising edges
// the two lanes alternate, so a lane is never rewritten while its lower
// nibble is still being resolved
module apo_hold #(
   parameter int WORD_W = `APO_WORD_W
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // quantised input
   input wire logic [WORD_W-1:0] ain_code,
   // held samples
   output apo_pkg::apo_hold_t hold
);
   apo_pkg::apo_hold_t hold_r;
   apo_pkg::apo_hold_t hold_nxt;

   initial begin
      if (WORD_W != `APO_WORD_W) begin
         $error("hold width must match the package word width");
      end
   end

   always_comb begin
      hold_nxt = hold_r;
      hold_nxt.taken = 1'b1;
      hold_nxt.last_lane = hold_r.lane;
      hold_nxt.lane = ~hold_r.lane;
      if (hold_r.lane == 1'b0) begin
         hold_nxt.code_a = ain_code;
      end else begin
         hold_nxt.code_b = ain_code;
      end
   end

   // falling edge register: this is the converter's sample instant
   always_ff @(negedge mclk or negedge nrst) begin
      if (!nrst) begin
         hold_r <= '{
            code_a: '0,
            code_b: '0,
            lane: `APO_RST_LANE,
            last_lane: `APO_RST_LANE,
            taken: 1'b0
         };
      end else begin
         hold_r <= hold_nxt;
      end
   end

   assign hold = hold_r;
endmodule // apo_hold

module apo_port #(
   parameter int WORD_W = `APO_WORD_W,
   parameter int FIFO_DEPTH = `APO_FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // quantised analog input, 00 at reference_bottom, FF at reference_top
   input wire logic [WORD_W-1:0] ain_code,
   // output enable pin
   input wire logic oe_n,
   // three-state data pins, index 1 is the msb
   output logic [1:WORD_W] data_pin_o,
   output logic [1:WORD_W] data_pin_oe,
   // capture stream
   output logic [WORD_W-1:0] cap_data,
   output logic cap_valid,
   input wire logic cap_ready,
   // buffer status
   output logic buf_ready,
   output logic overrun
);
   // held samples, rising edge pipeline and capture buffer handshake
   apo_pkg::apo_hold_t hold;
   apo_pkg::apo_state_t st_r;
   apo_pkg::apo_state_t st_nxt;
   logic [WORD_W-1:0] upper_src;
   logic [WORD_W-1:0] lower_src;
   logic fifo_in_ready;
   logic fifo_in_valid;

   localparam apo_pkg::apo_state_t ST_RST = '{
      oe_s1: `APO_RST_OE_N,
      oe_s2: `APO_RST_OE_N,
      fill: apo_pkg::APO_EMPTY,
      upper_stage_result: '0,
      up_lane: `APO_RST_LANE,
      lower_stage_result: '0,
      lo_upper: '0,
      word: `APO_CODE_ZERO,
      word_v: 1'b0,
      overrun: 1'b0
   };

   initial begin
      if (WORD_W != `APO_WORD_W) begin
         $error("port width must match the package word width");
      end
      if (WORD_W != 2 * `APO_NIB_W) begin
         $error("port width must be two comparator nibbles");
      end
      if (FIFO_DEPTH < 2) begin
         $error("capture buffer needs at least two words");
      end
   end

   // the falling edge register is the converter's own hold, so the input is
   // not synchronised: two more stages would break the 2.5 cycle latency
   apo_hold #(
      .WORD_W(WORD_W)
   ) u_hold (
      .mclk(mclk),
      .nrst(nrst),
      .ain_code(ain_code),
      .hold(hold)
   );

   // the upper group reads the lane filled at the last falling edge; the
   // lower group reads the lane recorded one edge earlier, which the other
   // lane's sample has left alone
   always_comb begin
      if (hold.last_lane) begin
         upper_src = hold.code_b;
      end else begin
         upper_src = hold.code_a;
      end
      if (st_r.up_lane) begin
         lower_src = hold.code_b;
      end else begin
         lower_src = hold.code_a;
      end
   end

   always_comb begin
      st_nxt = st_r;
      // two stages on the enable pin, it comes from outside the clock domain
      st_nxt.oe_s1 = oe_n;
      st_nxt.oe_s2 = st_r.oe_s1;
      // upper nibble settles on the first rising edge after the sample
      st_nxt.upper_stage_result = upper_src[`APO_UPPER_LSB +: `APO_NIB_W];
      st_nxt.up_lane = hold.last_lane;
      // lower nibble one edge later, with the upper nibble carried along
      st_nxt.lower_stage_result = lower_src[`APO_LOWER_LSB +: `APO_NIB_W];
      st_nxt.lo_upper = st_r.upper_stage_result;
      // combined word on the third rising edge, no recoding of the code
      st_nxt.word = {st_r.lo_upper, st_r.lower_stage_result};
      st_nxt.word_v = (st_r.fill == apo_pkg::APO_FILL2) ||
         (st_r.fill == apo_pkg::APO_RUN);
      case (st_r.fill)
         apo_pkg::APO_EMPTY: begin
            if (hold.taken) begin
               st_nxt.fill = apo_pkg::APO_FILL1;
            end
         end
         apo_pkg::APO_FILL1: begin
            st_nxt.fill = apo_pkg::APO_FILL2;
         end
         apo_pkg::APO_FILL2: begin
            st_nxt.fill = apo_pkg::APO_RUN;
         end
         apo_pkg::APO_RUN: begin
            st_nxt.fill = apo_pkg::APO_RUN;
         end
         default: begin
            st_nxt.fill = apo_pkg::APO_EMPTY;
         end
      endcase
      // sticky until reset: the converter cannot pause, so a word that the
      // buffer refuses is lost and the loss must stay visible
      if (fifo_in_valid && !fifo_in_ready) begin
         st_nxt.overrun = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pin 1 carries the msb; the word is driven even while disabled so the
   // enable alone decides what reaches the bus
   for (genvar i = 1; i <= WORD_W; i++) begin : g_pin
      assign data_pin_o[i] = st_r.word[WORD_W - i];
      assign data_pin_oe[i] = ~st_r.oe_s2;
   end

   // eight words absorb capture stalls; a longer stall sets the overrun flag
   // rather than holding up the converter
   apo_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .in_data(st_r.word),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(cap_data),
      .out_valid(cap_valid),
      .out_ready(cap_ready)
   );

   // buffer status straight from the flags
   assign fifo_in_valid = st_r.word_v;
   assign buf_ready = fifo_in_ready;
   assign overrun = st_r.overrun;
endmodule // apo_port

// >>> apo_checker.sv
// pin checks for apo_port
// bound into apo_port, sees its ports only
`timescale 1ns/1ps
module apo_chk (
   // clock, reset, inputs
   input wire logic mclk, nrst, oe_n,
   input wire logic [7:0] ain_code,
   // pins
   input wire logic [1:8] data_pin_o, data_pin_oe
);
   logic [7:0] s_r, a_r, b_r, c_r;
   logic [2:0] n_r;
   always_ff @(negedge mclk) s_r <= ain_code;
   always_ff @(posedge mclk) {c_r, b_r, a_r} <= {b_r, a_r, s_r};
   always_ff @(posedge mclk or negedge nrst) n_r <= !nrst ? 3'h0 : n_r + 3'(~&n_r);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // pipeline counted full only after refill, so a mid-run reset is safe
   sequence r; &n_r; endsequence
   property p_lat; r |-> data_pin_o == c_r; endproperty
   a_lat: assert property (p_lat) else $error("word");
   property p_nxt; r |=> data_pin_o == $past(b_r); endproperty
   a_nxt: assert property (p_nxt) else $error("next");
   property p_msb; r |-> data_pin_o[1] == c_r[7]; endproperty
   a_msb: assert property (p_msb) else $error("msb");
   property p_lsb; r |-> data_pin_o[8] == c_r[0]; endproperty
   a_lsb: assert property (p_lsb) else $error("lsb");
   property p_new; r ##1 $changed(c_r) |-> $changed(data_pin_o); endproperty
   a_new: assert property (p_new) else $error("rate");
   property p_off; oe_n [*3] |-> data_pin_oe == 8'h00; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_on; (!oe_n) [*3] |-> data_pin_oe == 8'hFF; endproperty
   a_on: assert property (p_on) else $error("on");
   property p_dis; $rose(oe_n) |-> ##[1:2] data_pin_oe == 8'h00; endproperty
   a_dis: assert property (p_dis) else $error("dis");
endmodule // apo_chk
bind apo_port apo_chk chk (.mclk, .nrst, .oe_n, .ain_code, .data_pin_o, .data_pin_oe);

// >>> apo_cap_sink.sv
// capture logic model, takes words, stalls on request
// assumes the bench owns stall
`timescale 1ns/1ps
module apo_cap_sink (
   // clock, control, stream
   input wire logic mclk, stall, cap_valid,
   input wire logic [7:0] cap_data,
   output logic cap_ready = 1'b0,
   output logic [7:0] last_word = 8'h00
);
   always @(negedge mclk) cap_ready <= ~stall;
   always @(posedge mclk) if (cap_valid && cap_ready) last_word <= cap_data;
endmodule // apo_cap_sink

// >>> apo_port_tb.sv
// bench for apo_port with the capture model
// checker arrives by bind
`timescale 1ns/1ps
module apo_port_tb;
   logic mclk = 1'b0, nrst = 1'b0, oe_n = 1'b0, stall = 1'b0;
   logic cap_valid, cap_ready, buf_ready, overrun;
   logic [7:0] ain_code = 8'h00, cap_data, last_word;
   logic [1:8] data_pin_o, data_pin_oe;
   int err_total = 0, total_checks = 0;
   apo_port dut (.mclk, .nrst, .ain_code, .oe_n, .data_pin_o, .data_pin_oe, .cap_data,
      .cap_valid, .cap_ready, .buf_ready, .overrun);
   apo_cap_sink sink (.mclk, .stall, .cap_data, .cap_valid, .cap_ready, .last_word);
   initial forever #5 mclk = ~mclk;
   task automatic chk(input logic [7:0] s, e);
      total_checks++;
      if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
      err_total += int'(s !== e);
   endtask
   task automatic final_report;
      if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_codes;
      logic [7:0] c [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
      for (int i = 0; i < 16; i++) @(negedge mclk) ain_code <= 8'(i * 37);
      foreach (c[i]) begin
         @(negedge mclk) ain_code <= c[i];
         repeat (5) @(negedge mclk);
         chk(data_pin_o, c[i]);
         chk(data_pin_oe, 8'hFF);
      end
   endtask
   task automatic t_buf;
      int n;
      stall <= 1'b1;
      for (n = 0; n < 40 && buf_ready !== 1'b0; n++) @(negedge mclk);
      chk({7'h00, buf_ready}, 8'h00);
      if (n == 40) return;
      @(negedge mclk);
      chk({7'h00, overrun}, 8'h01);
      stall <= 1'b0;
      oe_n <= 1'b1;
      repeat (30) @(negedge mclk);
      chk(last_word, 8'hFF);
      chk(data_pin_oe, 8'h00);
   endtask
   task automatic t_reset;
      @(negedge mclk) nrst <= 1'b0;
      repeat (2) @(negedge mclk);
      chk({6'h00, overrun, cap_valid}, 8'h00);
      nrst <= 1'b1;
      @(negedge mclk);
      chk(data_pin_o, 8'h00);
      repeat (6) @(negedge mclk);
      chk(data_pin_o, ain_code);
      chk({7'h00, cap_valid}, 8'h01);
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      nrst <= 1'b1;
      t_codes();
      t_buf();
      t_reset();
      final_report();
   end
endmodule // apo_port_tb
